// ===== rtl/trd_run_decoder.sv
// Terminal run command decoder with filtering, polarity, delays and UP/DOWN ramp.
//
// Functional notes
// - Mode 1: input one is run enable, input two selects direction.
// - Mode 1: enabled gives forward, or reverse with direction active; else stop.
// - Mode 2: input three enables; inputs one and two give forward and reverse.
// - Mode 2: presses latch forward or reverse; the latest press wins, and input one wins a tie.
// - Three-wire modes: enable going inactive clears the latch and stops at once.
// - Mode 3: input three enables, input one runs, input two is direction level.
// - Mode 3: run press starts; direction follows the direction level.
// - Enable must stay held; a press acts on its turn-on edge, not release.
// - UP/DOWN ramps the frequency at the set rate per second, default 1 Hz/s.
// - With two-decimal resolution the rate unit becomes 0.01 Hz/s.
// - Inputs one to five delay rises by ON delay, falls by OFF delay.
// - Polarity is decimal digits, units digit lowest input, two groups of five.
// - Digit 0: closed to common return is inactive, open is active.
// - Digit 1: closed to common return is active, open is inactive.
// - Mode 0: only input one gives forward, only input two reverse, else stop.
// - Every input is debounced, filter time 0 to 1 s, default 10 ms.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "trd_params.svh"

module trd_run_decoder #(
  parameter int MS_CYCLES = `TRD_MS_CYCLES
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  nrst_in,
  input  wire logic [9:0]            term_closed_in,
  input  wire trd_pkg::trd_bus_req_s bus_req_in,
  output logic [15:0]                bus_rdata_out,
  output logic                       forward_run_out,
  output logic                       reverse_run_out,
  output logic [19:0]                freq_setting_out
);

  trd_pkg::trd_state_s r;
  trd_pkg::trd_state_s n;

  logic [9:0]  pol;
  logic [9:0]  act;
  logic [9:0]  rise;
  logic [10:0] filt_lim;
  logic [15:0] dly_lim;
  logic [31:0] step;
  logic [31:0] max_acc;
  logic        enable;

  function automatic logic [15:0] pow10(input int k);
    case (k)
      0:       pow10 = 16'h0001;
      1:       pow10 = 16'h000A;
      2:       pow10 = 16'h0064;
      3:       pow10 = 16'h03E8;
      default: pow10 = 16'h2710;
    endcase
  endfunction

  // Returns whether polarity digit k of a decimal-coded group is nonzero.
  function automatic logic digit_set(input logic [15:0] v, input int k);
    logic [15:0] q;
    q = v / pow10(k);
    digit_set = ((q % 16'h000A) != 16'h0000);
  endfunction

  always_comb begin
    n            = r;
    n.ms_tick    = 1'b0;
    n.tenth_tick = 1'b0;
    n.rdata      = 16'h0000;
    pol          = 10'h000;
    act          = 10'h000;
    rise         = 10'h000;
    dly_lim      = 16'h0000;
    step         = 32'h0000_0000;
    max_acc      = `TRD_FREQ_MAX_MHZ * `TRD_UHZ_PER_MHZ;
    enable       = 1'b0;

    // Millisecond and tenth-second ticks form the single time base.
    if (r.ms_cnt >= 24'(MS_CYCLES - 1)) begin
      n.ms_cnt  = 24'h000000;
      n.ms_tick = 1'b1;
      if (r.tenth_cnt >= `TRD_TENTH_MS - 7'h01) begin
        n.tenth_cnt  = 7'h00;
        n.tenth_tick = 1'b1;
      end else begin
        n.tenth_cnt = r.tenth_cnt + 7'h01;
      end
    end else begin
      n.ms_cnt = r.ms_cnt + 24'h000001;
    end

    // Three-stage synchroniser on every terminal.
    n.sync1 = term_closed_in;
    n.sync2 = r.sync1;
    n.sync3 = r.sync2;

    filt_lim = (r.filt_time > 16'(`TRD_FILT_MAX_MS)) ? `TRD_FILT_MAX_MS : r.filt_time[10:0];
    for (int i = 0; i < 10; i++) begin
      // A change is taken once it has stood for the filter time.
      if (r.sync3[i] == r.filt[i]) begin
        n.fcnt[i] = 11'h000;
      end else if (r.sync2[i] == r.sync3[i]) begin
        if (r.fcnt[i] >= filt_lim) begin
          n.filt[i] = r.sync3[i];
          n.fcnt[i] = 11'h000;
        end else if (r.ms_tick) begin
          n.fcnt[i] = r.fcnt[i] + 11'h001;
        end
      end
      // Polarity correction follows the filter.
      if (digit_set(i < 5 ? r.pol_lo : r.pol_hi, i % 5)) begin
        pol[i] = r.filt[i];
      end else begin
        pol[i] = ~r.filt[i];
      end
    end

    for (int i = 0; i < 5; i++) begin
      // Rising changes wait the ON delay, falling ones the OFF delay.
      dly_lim = pol[i] ? r.delay[2*i] : r.delay[2*i+1];
      if (pol[i] == r.dly[i]) begin
        n.dcnt[i] = 16'h0000;
      end else if (r.dcnt[i] >= dly_lim) begin
        n.dly[i]  = pol[i];
        n.dcnt[i] = 16'h0000;
      end else if (r.tenth_tick) begin
        n.dcnt[i] = r.dcnt[i] + 16'h0001;
      end
    end

    act        = {pol[9:5], r.dly};
    rise       = act & ~r.prev_act;
    n.prev_act = act;

    case (r.mode[1:0])
      `TRD_MODE_TWO_1: begin
        n.run_fwd   = act[0] & ~act[1];
        n.run_rev   = act[1] & ~act[0];
        n.latch_run = 1'b0;
        n.latch_rev = 1'b0;
      end
      `TRD_MODE_TWO_2: begin
        n.run_fwd   = act[0] & ~act[1];
        n.run_rev   = act[0] & act[1];
        n.latch_run = 1'b0;
        n.latch_rev = 1'b0;
      end
      `TRD_MODE_THREE_1: begin
        enable = act[2];
        if (!enable) begin
          n.latch_run = 1'b0;
        end else if (rise[0]) begin
          n.latch_run = 1'b1;
          n.latch_rev = 1'b0;
        end else if (rise[1]) begin
          n.latch_run = 1'b1;
          n.latch_rev = 1'b1;
        end
        n.run_fwd = n.latch_run & ~n.latch_rev;
        n.run_rev = n.latch_run & n.latch_rev;
      end
      `TRD_MODE_THREE_2: begin
        enable = act[2];
        if (!enable) begin
          n.latch_run = 1'b0;
        end else if (rise[0]) begin
          n.latch_run = 1'b1;
        end
        n.latch_rev = act[1];
        n.run_fwd   = n.latch_run & ~act[1];
        n.run_rev   = n.latch_run & act[1];
      end
      default: begin
        n.run_fwd = 1'b0;
        n.run_rev = 1'b0;
      end
    endcase

    // Accumulator is in micro-hertz; each millisecond adds the rate in mHz/s.
    if (r.resol == `TRD_RESOL_TWO_DEC) begin
      step = 32'(r.rate) * 32'h0000_000A;
    end else begin
      step = 32'(r.rate);
    end
    if (r.ms_tick && (act[3] != act[4])) begin
      if (act[3]) begin
        n.acc = (max_acc - r.acc < step) ? max_acc : r.acc + step;
      end else begin
        n.acc = (r.acc < step) ? 32'h0000_0000 : r.acc - step;
      end
    end
    n.freq = 20'(n.acc / `TRD_UHZ_PER_MHZ);

    if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        `TRD_ADDR_MODE:      n.mode      = bus_req_in.wdata;
        `TRD_ADDR_RATE:      n.rate      = bus_req_in.wdata;
        `TRD_ADDR_POL_LO:    n.pol_lo    = bus_req_in.wdata;
        `TRD_ADDR_POL_HI:    n.pol_hi    = bus_req_in.wdata;
        `TRD_ADDR_FILT_TIME: n.filt_time = bus_req_in.wdata;
        `TRD_ADDR_RESOL:     n.resol     = bus_req_in.wdata;
        default: begin
          if (bus_req_in.addr >= `TRD_ADDR_DELAY_BASE &&
              bus_req_in.addr <= `TRD_ADDR_DELAY_LAST) begin
            n.delay[4'(bus_req_in.addr - `TRD_ADDR_DELAY_BASE)] = bus_req_in.wdata;
          end
        end
      endcase
    end

    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        `TRD_ADDR_MODE:      n.rdata = r.mode;
        `TRD_ADDR_RATE:      n.rdata = r.rate;
        `TRD_ADDR_POL_LO:    n.rdata = r.pol_lo;
        `TRD_ADDR_POL_HI:    n.rdata = r.pol_hi;
        `TRD_ADDR_FILT_TIME: n.rdata = r.filt_time;
        `TRD_ADDR_RESOL:     n.rdata = r.resol;
        `TRD_ADDR_LEVELS:    n.rdata = {6'h00, act};
        `TRD_ADDR_RUN:       n.rdata = {14'h0000, r.run_rev, r.run_fwd};
        `TRD_ADDR_FREQ_LO:   n.rdata = r.freq[15:0];
        `TRD_ADDR_FREQ_HI:   n.rdata = {12'h000, r.freq[19:16]};
        default: begin
          if (bus_req_in.addr >= `TRD_ADDR_DELAY_BASE &&
              bus_req_in.addr <= `TRD_ADDR_DELAY_LAST) begin
            n.rdata = r.delay[4'(bus_req_in.addr - `TRD_ADDR_DELAY_BASE)];
          end else begin
            n.rdata = 16'h0000;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r           <= '0;
      r.mode      <= `TRD_RST_MODE;
      r.rate      <= `TRD_RST_RATE;
      r.delay     <= {10{`TRD_RST_DELAY}};
      r.pol_lo    <= `TRD_RST_POL;
      r.pol_hi    <= `TRD_RST_POL;
      r.filt_time <= `TRD_RST_FILT_TIME;
      r.resol     <= `TRD_RST_RESOL;
    end else begin
      r <= n;
    end
  end

  assign bus_rdata_out    = r.rdata;
  assign forward_run_out  = r.run_fwd;
  assign reverse_run_out  = r.run_rev;
  assign freq_setting_out = r.freq;

endmodule // trd_run_decoder

// ===== rtl/trd_params.svh
// Offsets, reset values and timing counts of the terminal run command decoder.
`ifndef TRD_PARAMS_SVH
`define TRD_PARAMS_SVH
`define TRD_ADDR_MODE        8'h00
`define TRD_ADDR_RATE        8'h01
`define TRD_ADDR_DELAY_BASE  8'h02
`define TRD_ADDR_DELAY_LAST  8'h0B
`define TRD_ADDR_POL_LO      8'h0C
`define TRD_ADDR_POL_HI      8'h0D
`define TRD_ADDR_FILT_TIME   8'h0E
`define TRD_ADDR_RESOL       8'h0F
`define TRD_ADDR_LEVELS      8'h10
`define TRD_ADDR_RUN         8'h11
`define TRD_ADDR_FREQ_LO     8'h12
`define TRD_ADDR_FREQ_HI     8'h13
`define TRD_MODE_TWO_1       2'h0
`define TRD_MODE_TWO_2       2'h1
`define TRD_MODE_THREE_1     2'h2
`define TRD_MODE_THREE_2     2'h3
`define TRD_RST_MODE         16'h0000
`define TRD_RST_RATE         16'h03E8
`define TRD_RST_DELAY        16'h0000
`define TRD_RST_POL          16'h0000
`define TRD_RST_FILT_TIME    16'h000A
`define TRD_RST_RESOL        16'h0002
`define TRD_RESOL_TWO_DEC    16'h0001
`define TRD_FILT_MAX_MS      11'h3E8
`define TRD_CLK_PERIOD_NS    5
`define TRD_MS_TIME_NS       1000000
`define TRD_MS_CYCLES        (`TRD_MS_TIME_NS / `TRD_CLK_PERIOD_NS)
`define TRD_TENTH_MS         7'h64
`define TRD_UHZ_PER_MHZ      32'h0000_03E8
`define TRD_FREQ_MAX_MHZ     32'h000A_0000
`endif

// ===== rtl/trd_pkg.sv
// Types shared by the terminal run command decoder.
package trd_pkg;
  localparam int NUM_IN  = 10;
  localparam int NUM_DLY = 5;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } trd_bus_req_s;

  typedef struct packed {
    logic [NUM_IN-1:0]             sync1;
    logic [NUM_IN-1:0]             sync2;
    logic [NUM_IN-1:0]             sync3;
    logic [NUM_IN-1:0]             filt;
    logic [NUM_IN-1:0][10:0]       fcnt;
    logic [NUM_DLY-1:0]            dly;
    logic [NUM_DLY-1:0][15:0]      dcnt;
    logic [23:0]                   ms_cnt;
    logic [6:0]                    tenth_cnt;
    logic                          ms_tick;
    logic                          tenth_tick;
    logic [NUM_IN-1:0]             prev_act;
    logic                          run_fwd;
    logic                          run_rev;
    logic                          latch_run;
    logic                          latch_rev;
    logic [31:0]                   acc;
    logic [19:0]                   freq;
    logic [15:0]                   mode;
    logic [15:0]                   rate;
    logic [2*NUM_DLY-1:0][15:0]    delay;
    logic [15:0]                   pol_lo;
    logic [15:0]                   pol_hi;
    logic [15:0]                   filt_time;
    logic [15:0]                   resol;
    logic [15:0]                   rdata;
  } trd_state_s;
endpackage

// ===== testbench/trd_operator.sv
// Operator switch model for the input terminals.
`timescale 1ns/1ps
module trd_operator (
  input  wire logic [9:0] contact_in,
  output logic      [9:0] term_closed_out
);
  // A made contact closes its terminal; the bench keeps enable made while running.
  assign term_closed_out = contact_in;
endmodule  // trd_operator

// ===== testbench/trd_run_decoder_chk.sv
// Port checker for the terminal run command decoder.
`timescale 1ns/1ps
`include "trd_params.svh"
module trd_run_decoder_chk (
  input wire logic                  ref_clk_in,
  input wire logic                  nrst_in,
  input wire logic [9:0]            term_closed_in,
  input wire trd_pkg::trd_bus_req_s bus_req_in,
  input wire logic [15:0]           bus_rdata_out,
  input wire logic                  forward_run_out,
  input wire logic                  reverse_run_out,
  input wire logic [19:0]           freq_setting_out
);
  logic [1:0]  mode_reg;
  logic [15:0] rate_reg;
  logic        rd_a;
  assign rd_a = bus_req_in.rd;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // Mirrors of the written mode and rate values.
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_reg <= 2'h0;
      rate_reg <= `TRD_RST_RATE;
    end else if (bus_req_in.wr && bus_req_in.addr == `TRD_ADDR_MODE) begin
      mode_reg <= bus_req_in.wdata[1:0];
    end else if (bus_req_in.wr && bus_req_in.addr == `TRD_ADDR_RATE) begin
      rate_reg <= bus_req_in.wdata;
    end
  end
  property p_idle; !$past(rd_a) |-> bus_rdata_out == 16'h0000; endproperty
  property p_mode; rd_a && bus_req_in.addr == `TRD_ADDR_MODE |=> bus_rdata_out[1:0] == mode_reg;
  endproperty
  property p_rate; rd_a && bus_req_in.addr == `TRD_ADDR_RATE |=> bus_rdata_out == rate_reg;
  endproperty
  property p_unmap; rd_a && bus_req_in.addr > `TRD_ADDR_FREQ_HI |=> bus_rdata_out == 16'h0000;
  endproperty
  property p_stat; rd_a && bus_req_in.addr == `TRD_ADDR_RUN |=>
    bus_rdata_out == {14'h0000, $past(reverse_run_out), $past(forward_run_out)}; endproperty
  property p_excl; !(forward_run_out && reverse_run_out); endproperty
  property p_fmax; freq_setting_out <= 20'hA0000; endproperty
  property p_step; $changed(freq_setting_out) |-> ((freq_setting_out > $past(freq_setting_out)) ?
    freq_setting_out - $past(freq_setting_out) : $past(freq_setting_out) - freq_setting_out)
    <= 20'h00290; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
  a_mode: assert property (p_mode) else $error("mode readback wrong");
  a_rate: assert property (p_rate) else $error("rate readback wrong");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_stat: assert property (p_stat) else $error("run status wrong");
  a_excl: assert property (p_excl) else $error("both directions");
  a_fmax: assert property (p_fmax) else $error("frequency above limit");
  a_step: assert property (p_step) else $error("frequency step too big");
  c_fwd: cover property ($rose(forward_run_out));
  c_rev: cover property ($rose(reverse_run_out));
  c_freq: cover property ($rose(freq_setting_out[9]));
endmodule  // trd_run_decoder_chk
bind trd_run_decoder trd_run_decoder_chk chk_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
  .term_closed_in(term_closed_in), .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
  .forward_run_out(forward_run_out), .reverse_run_out(reverse_run_out),
  .freq_setting_out(freq_setting_out));

// ===== testbench/testbench.sv
// Self-checking bench for the terminal run command decoder.
`timescale 1ns/1ps
`include "trd_params.svh"
module testbench;
  logic                  clk;
  logic                  nrst;
  logic [9:0]            sw;
  logic [9:0]            term;
  trd_pkg::trd_bus_req_s req;
  logic [15:0]           rdata;
  logic                  forward_run;
  logic                  reverse_run;
  logic [19:0]           freq;
  logic [19:0]           f0;
  int                    bad_count;
  int                    checks_done;
  trd_operator op (.contact_in(sw), .term_closed_out(term));
  trd_run_decoder #(.MS_CYCLES(20)) dut (.ref_clk_in(clk), .nrst_in(nrst), .term_closed_in(term),
    .bus_req_in(req), .bus_rdata_out(rdata), .forward_run_out(forward_run), .reverse_run_out(reverse_run),
    .freq_setting_out(freq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1;
    chk("rdata", {4'h0, exp}, {4'h0, rdata});
  endtask
  task automatic push(input logic [9:0] v, input int n);
    @(posedge clk);
    sw <= v;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic run_is(input logic f, input logic r, input int bound);
    int n;
    n = 0;
    while ({forward_run, reverse_run} !== {f, r} && n < bound) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("run", {18'h0, f, r}, {18'h0, forward_run, reverse_run});
    if (bound > 0 && {forward_run, reverse_run} !== {f, r}) print_verdict();
  endtask
  task automatic step(input logic [9:0] v, input logic f, input logic r);
    push(v, 20);
    run_is(f, r, 40);
  endtask
  task automatic ramp(input logic [9:0] v, input logic [19:0] lo, input logic [19:0] hi);
    f0 = freq;
    push(v, 2000);
    chk("ramp", 20'h1, {19'h0, (v[3] ? freq - f0 : f0 - freq) inside {[lo:hi]}});
  endtask
  initial begin
    nrst = 1'b0;
    sw = 10'h000;
    req = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(`TRD_ADDR_MODE, `TRD_RST_MODE);
    rd(`TRD_ADDR_RATE, `TRD_RST_RATE);
    rd(`TRD_ADDR_DELAY_BASE, `TRD_RST_DELAY);
    rd(`TRD_ADDR_POL_LO, `TRD_RST_POL);
    rd(`TRD_ADDR_POL_HI, `TRD_RST_POL);
    rd(`TRD_ADDR_FILT_TIME, `TRD_RST_FILT_TIME);
    rd(`TRD_ADDR_RESOL, `TRD_RST_RESOL);
    rd(8'h20, 16'h0000);
    push(10'h002, 100);
    run_is(1'b0, 1'b0, 0);
    run_is(1'b1, 1'b0, 300);
    rd(`TRD_ADDR_RUN, 16'h0001);
    wr(`TRD_ADDR_FILT_TIME, 16'h0000);
    wr(`TRD_ADDR_POL_LO, 16'h2B67);
    step(10'h000, 1'b0, 1'b0);
    step(10'h001, 1'b1, 1'b0);
    step(10'h002, 1'b0, 1'b1);
    rd(`TRD_ADDR_RUN, 16'h0002);
    step(10'h003, 1'b0, 1'b0);
    wr(`TRD_ADDR_MODE, 16'h0001);
    rd(`TRD_ADDR_MODE, 16'h0001);
    step(10'h001, 1'b1, 1'b0);
    step(10'h003, 1'b0, 1'b1);
    step(10'h002, 1'b0, 1'b0);
    wr(`TRD_ADDR_MODE, 16'h0002);
    step(10'h001, 1'b0, 1'b0);
    step(10'h004, 1'b0, 1'b0);
    step(10'h005, 1'b1, 1'b0);
    step(10'h004, 1'b1, 1'b0);
    step(10'h006, 1'b0, 1'b1);
    step(10'h000, 1'b0, 1'b0);
    wr(`TRD_ADDR_MODE, 16'h0003);
    step(10'h004, 1'b0, 1'b0);
    step(10'h005, 1'b1, 1'b0);
    step(10'h006, 1'b0, 1'b1);
    step(10'h002, 1'b0, 1'b0);
    wr(`TRD_ADDR_MODE, 16'h0001);
    wr(`TRD_ADDR_DELAY_BASE, 16'h0002);
    push(10'h001, 1900);
    run_is(1'b0, 1'b0, 0);
    run_is(1'b1, 1'b0, 2300);
    step(10'h000, 1'b0, 1'b0);
    ramp(10'h008, 20'd97, 20'd102);
    wr(`TRD_ADDR_RESOL, `TRD_RESOL_TWO_DEC);
    ramp(10'h008, 20'd970, 20'd1020);
    ramp(10'h010, 20'd970, 20'd1020);
    print_verdict();
  end
endmodule  // testbench
